// [rtl/nbs_bar_cfg.sv]
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "nbs_consts.svh"
module nbs_bar_cfg
   import nbs_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_resetn,
   input wire logic i_por_n,
   input wire logic i_s_axi_awvalid,
   output logic o_s_axi_awready,
   input wire logic [11:0] i_s_axi_awaddr,
   input wire logic [2:0] i_s_axi_awprot,
   input wire logic i_s_axi_wvalid,
   output logic o_s_axi_wready,
   input wire logic [31:0] i_s_axi_wdata,
   input wire logic [3:0] i_s_axi_wstrb,
   output logic o_s_axi_bvalid,
   input wire logic i_s_axi_bready,
   output logic [1:0] o_s_axi_bresp,
   input wire logic i_s_axi_arvalid,
   output logic o_s_axi_arready,
   input wire logic [11:0] i_s_axi_araddr,
   input wire logic [2:0] i_s_axi_arprot,
   output logic o_s_axi_rvalid,
   input wire logic i_s_axi_rready,
   output logic [31:0] o_s_axi_rdata,
   output logic [1:0] o_s_axi_rresp,
   output nbs_win_s o_win2,
   output nbs_win_s o_win3,
   output logic o_pair64,
   output logic [63:0] o_win2_tbase
);

   nbs_cfg_s cfg_q;
   nbs_cfg_s cfg_d;
   nbs_bus_s bus_q;
   nbs_bus_s bus_d;
   logic pair_now;
   logic wr_go;
   logic wr_ok;

   // Byte-lane merge that also clears every bit outside the mask.
   function automatic logic [31:0] merge(
      input logic [31:0] old_v,
      input logic [31:0] new_v,
      input logic [3:0] strb,
      input logic [31:0] mask
   );
      logic [31:0] v;
      v = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            v[8*i +: 8] = new_v[8*i +: 8];
         end
      end
      return v & mask;
   endfunction

   // Setup word with the addressing type forced to zero for I/O space.
   function automatic logic [31:0] fix_setup(input logic [31:0] v);
      logic [31:0] r;
      r = v;
      if (r[`NBS_SPACE_SELECT_BIT]) begin
         r[`NBS_TYPE_MSB:`NBS_TYPE_LSB] = `NBS_TYPE_32;
      end
      return r;
   endfunction

   // Attributes a window reports to the translation path.
   function automatic nbs_win_s win_of(
      input logic [31:0] v,
      input logic alive
   );
      nbs_win_s w;
      w = '0;
      if (alive && v[`NBS_EN_BIT]) begin
         w.en = 1'b1;
         w.space_select = v[`NBS_SPACE_SELECT_BIT];
         w.addr_type = v[`NBS_TYPE_MSB:`NBS_TYPE_LSB];
         w.prefetchable_select = v[`NBS_PREFETCHABLE_SELECT_BIT];
         w.size = v[`NBS_SIZE_MSB:`NBS_SIZE_LSB];
      end
      return w;
   endfunction

   assign pair_now = !cfg_q.w2_setup[`NBS_SPACE_SELECT_BIT] &&
      (cfg_q.w2_setup[`NBS_TYPE_MSB:`NBS_TYPE_LSB] == `NBS_TYPE_64);
   assign wr_go = !bus_q.awready && !bus_q.wready && !bus_q.bvalid;

   always_comb begin
      cfg_d = cfg_q;
      bus_d = bus_q;
      wr_ok = 1'b0;
      if (i_s_axi_awvalid && bus_q.awready) begin
         bus_d.awready = 1'b0;
         bus_d.awaddr = i_s_axi_awaddr;
      end
      if (i_s_axi_wvalid && bus_q.wready) begin
         bus_d.wready = 1'b0;
         bus_d.wdata = i_s_axi_wdata;
         bus_d.wstrb = i_s_axi_wstrb;
      end
      if (wr_go) begin
         if (bus_q.awaddr == `NBS_W2_SETUP_OFF) begin
            wr_ok = 1'b1;
            cfg_d.w2_setup = fix_setup(merge(cfg_q.w2_setup,
               bus_q.wdata, bus_q.wstrb, `NBS_SETUP_MASK));
         end else if (bus_q.awaddr == `NBS_W1_TBASE_OFF) begin
            wr_ok = 1'b1;
            cfg_d.w1_tbase = merge(cfg_q.w1_tbase, bus_q.wdata,
               bus_q.wstrb, `NBS_W1TB_MASK);
         end else if (bus_q.awaddr == `NBS_W2_TBASE_OFF) begin
            wr_ok = 1'b1;
            cfg_d.w2_tbase = merge(cfg_q.w2_tbase, bus_q.wdata,
               bus_q.wstrb, `NBS_TBASE_MASK);
         end else if (bus_q.awaddr == `NBS_W3_SETUP_OFF) begin
            wr_ok = 1'b1;
            if (!pair_now) begin
               cfg_d.w3_setup = fix_setup(merge(cfg_q.w3_setup,
                  bus_q.wdata, bus_q.wstrb, `NBS_SETUP_MASK));
            end
         end
         bus_d.bvalid = 1'b1;
         bus_d.bresp = wr_ok ? `NBS_RESP_OKAY : `NBS_RESP_SLVERR;
      end
      if (bus_q.bvalid && i_s_axi_bready) begin
         bus_d.bvalid = 1'b0;
         bus_d.awready = 1'b1;
         bus_d.wready = 1'b1;
      end
      if (i_s_axi_arvalid && bus_q.arready) begin
         bus_d.arready = 1'b0;
         bus_d.rvalid = 1'b1;
         bus_d.rresp = `NBS_RESP_OKAY;
         if (i_s_axi_araddr == `NBS_W2_SETUP_OFF) begin
            bus_d.rdata = cfg_q.w2_setup;
         end else if (i_s_axi_araddr == `NBS_W1_TBASE_OFF) begin
            bus_d.rdata = cfg_q.w1_tbase;
         end else if (i_s_axi_araddr == `NBS_W2_TBASE_OFF) begin
            bus_d.rdata = cfg_q.w2_tbase;
         end else if (i_s_axi_araddr == `NBS_W3_SETUP_OFF) begin
            bus_d.rdata = pair_now ? 32'h0000_0000 : cfg_q.w3_setup;
         end else begin
            bus_d.rdata = 32'h0000_0000;
            bus_d.rresp = `NBS_RESP_SLVERR;
         end
      end
      if (bus_q.rvalid && i_s_axi_rready) begin
         bus_d.rvalid = 1'b0;
         bus_d.arready = 1'b1;
      end
      cfg_d.pair64 = !cfg_d.w2_setup[`NBS_SPACE_SELECT_BIT] &&
         (cfg_d.w2_setup[`NBS_TYPE_MSB:`NBS_TYPE_LSB] == `NBS_TYPE_64);
      cfg_d.win2 = win_of(cfg_d.w2_setup, 1'b1);
      cfg_d.win3 = win_of(cfg_d.w3_setup, !cfg_d.pair64);
      cfg_d.tbase2 = {32'h0000_0000, cfg_d.w2_tbase};
      if (cfg_d.pair64) begin
         cfg_d.tbase2 = {cfg_d.w1_tbase, cfg_d.w2_tbase};
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_por_n) begin
      if (!i_por_n) begin
         cfg_q <= '0;
         cfg_q.w2_setup <= `NBS_CFG_RST;
         cfg_q.w1_tbase <= `NBS_CFG_RST;
         cfg_q.w2_tbase <= `NBS_CFG_RST;
         cfg_q.w3_setup <= `NBS_CFG_RST;
      end else begin
         cfg_q <= cfg_d;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         bus_q <= '0;
         bus_q.awready <= 1'b1;
         bus_q.wready <= 1'b1;
         bus_q.arready <= 1'b1;
      end else begin
         bus_q <= bus_d;
      end
   end

   assign o_s_axi_awready = bus_q.awready;
   assign o_s_axi_wready = bus_q.wready;
   assign o_s_axi_bvalid = bus_q.bvalid;
   assign o_s_axi_bresp = bus_q.bresp;
   assign o_s_axi_arready = bus_q.arready;
   assign o_s_axi_rvalid = bus_q.rvalid;
   assign o_s_axi_rdata = bus_q.rdata;
   assign o_s_axi_rresp = bus_q.rresp;
   assign o_win2 = cfg_q.win2;
   assign o_win3 = cfg_q.win3;
   assign o_pair64 = cfg_q.pair64;
   assign o_win2_tbase = cfg_q.tbase2;

endmodule
`default_nettype wire

// [rtl/nbs_consts.svh]
`ifndef NBS_CONSTS_SVH
`define NBS_CONSTS_SVH
`define NBS_W2_SETUP_OFF 12'h080
`define NBS_W1_TBASE_OFF 12'h088
`define NBS_W2_TBASE_OFF 12'h090
`define NBS_W3_SETUP_OFF 12'h094
`define NBS_SPACE_SELECT_BIT 0
`define NBS_TYPE_MSB 2
`define NBS_TYPE_LSB 1
`define NBS_PREFETCHABLE_SELECT_BIT 3
`define NBS_SIZE_MSB 9
`define NBS_SIZE_LSB 4
`define NBS_EN_BIT 31
`define NBS_TB_LSB 4
`define NBS_TYPE_32 2'h0
`define NBS_TYPE_64 2'h2
`define NBS_SETUP_MASK 32'h8000_03ff
`define NBS_TBASE_MASK 32'hffff_fff0
`define NBS_W1TB_MASK 32'hffff_ffff
`define NBS_CFG_RST 32'h0000_0000
`define NBS_RESP_OKAY 2'h0
`define NBS_RESP_SLVERR 2'h2
`endif

// [rtl/nbs_pkg.sv]
package nbs_pkg;
   typedef struct packed {
      logic en;
      logic space_select;
      logic [1:0] addr_type;
      logic prefetchable_select;
      logic [5:0] size;
   } nbs_win_s;
   typedef struct packed {
      logic [31:0] w2_setup;
      logic [31:0] w1_tbase;
      logic [31:0] w2_tbase;
      logic [31:0] w3_setup;
      nbs_win_s win2;
      nbs_win_s win3;
      logic pair64;
      logic [63:0] tbase2;
   } nbs_cfg_s;
   typedef struct packed {
      logic awready;
      logic [11:0] awaddr;
      logic wready;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } nbs_bus_s;
endpackage

// [sim/nbs_bar_cfg_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module nbs_bar_cfg_sva
   import nbs_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_resetn,
   input wire logic i_por_n,
   input wire logic i_s_axi_arvalid,
   input wire logic o_s_axi_arready,
   input wire logic o_s_axi_rvalid,
   input wire logic i_s_axi_rready,
   input wire logic o_s_axi_bvalid,
   input wire logic i_s_axi_bready,
   input wire logic [1:0] o_s_axi_bresp,
   input wire nbs_win_s o_win2,
   input wire nbs_win_s o_win3,
   input wire logic o_pair64,
   input wire logic [63:0] o_win2_tbase
);
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_resetn || !i_por_n);
   property p_off2; !o_win2.en |-> o_win2 == '0; endproperty
   a_off2: assert property (p_off2) else $error("win2 not zero");
   property p_off3; !o_win3.en |-> o_win3 == '0; endproperty
   a_off3: assert property (p_off3) else $error("win3 not zero");
   property p_pair; o_pair64 |-> o_win3 == '0; endproperty
   a_pair: assert property (p_pair) else $error("win3 shown");
   property p_io; o_win3.space_select |-> o_win3.addr_type == 2'h0; endproperty
   a_io: assert property (p_io) else $error("io type set");
   property p_up; !o_pair64 |-> o_win2_tbase[63:32] == 32'h0; endproperty
   a_up: assert property (p_up) else $error("upper base set");
   property p_ans; i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid;
   endproperty
   a_ans: assert property (p_ans) else $error("read late");
   property p_rh; o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid;
   endproperty
   a_rh: assert property (p_rh) else $error("rvalid dropped");
   property p_bh; o_s_axi_bvalid && !i_s_axi_bready |=>
      o_s_axi_bvalid && $stable(o_s_axi_bresp); endproperty
   a_bh: assert property (p_bh) else $error("bvalid dropped");
   cover property (o_pair64);
   cover property (o_s_axi_bvalid && o_s_axi_bresp == 2'h2);
   cover property (o_win3.en && o_win3.prefetchable_select);
endmodule
bind nbs_bar_cfg nbs_bar_cfg_sva u_sva (.*);
`default_nettype wire

// [sim/tb_nbs_bar_cfg.sv]
`timescale 1ns/1ps
`default_nettype none
`include "nbs_consts.svh"
module tb_nbs_bar_cfg import nbs_pkg::*;;
   logic clk = 0, rst_n = 0, por_n = 0;
   logic awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
   logic [11:0] awa = 0, ara = 0;
   logic [31:0] wd = 0, d, r, e, rdo;
   logic awr, wrdy, bv, arr, rv, p64;
   logic [1:0] br, rr;
   logic [63:0] tb;
   nbs_win_s w2, w3;
   integer failures = 0, cmp_count = 0, seed = 84884, i;
   initial forever #20 clk = ~clk;
   nbs_bar_cfg u_dut (.i_sys_clk(clk), .i_resetn(rst_n), .i_por_n(por_n),
      .i_s_axi_awvalid(awv), .o_s_axi_awready(awr), .i_s_axi_awaddr(awa),
      .i_s_axi_awprot(3'h0), .i_s_axi_wvalid(wv), .o_s_axi_wready(wrdy),
      .i_s_axi_wdata(wd), .i_s_axi_wstrb(4'hf), .o_s_axi_bvalid(bv),
      .i_s_axi_bready(bry), .o_s_axi_bresp(br), .i_s_axi_arvalid(arv),
      .o_s_axi_arready(arr), .i_s_axi_araddr(ara), .i_s_axi_arprot(3'h0),
      .o_s_axi_rvalid(rv), .i_s_axi_rready(rry), .o_s_axi_rdata(rdo),
      .o_s_axi_rresp(rr), .o_win2(w2), .o_win3(w3), .o_pair64(p64),
      .o_win2_tbase(tb));
   task chk(input logic [63:0] s, input logic [63:0] x);
      cmp_count++;
      if (s !== x) begin
         failures++;
         $display("wrong value at %0t seen %h expected %h", $time, s, x);
      end
   endtask
   task complete_run;
      $display("compares %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task bus_wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] x);
      @(posedge clk);
      awv <= 1;
      wv <= 1;
      awa <= a;
      wd <= v;
      bry <= 1;
      do begin
         @(posedge clk);
         if (awv && awr) awv <= 0;
         if (wv && wrdy) wv <= 0;
      end while (!(bv && bry));
      bry <= 0;
      chk(br, x);
   endtask
   task bus_rd(input logic [11:0] a, input logic [1:0] x, output logic [31:0] v);
      @(posedge clk);
      arv <= 1;
      ara <= a;
      rry <= 1;
      do begin
         @(posedge clk);
         if (arv && arr) arv <= 0;
      end while (!(rv && rry));
      v = rdo;
      rry <= 0;
      chk(rr, x);
   endtask
   // Works out the stored value of a setup word.
   function automatic logic [31:0] fs(input logic [31:0] v);
      fs = v & 32'h8000_03ff;
      if (v[0])
         fs[2:1] = 2'h0;
   endfunction
   initial begin
      #200000;
      failures++;
      complete_run;
   end
   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1;
      por_n <= 1;
      bus_rd(`NBS_W2_TBASE_OFF, 2'h0, r);
      chk(r, 32'h0);
      for (i = 0; i < 4; i++) begin
         d = i ? $random(seed) : 32'hffff_ffff;
         bus_wr(`NBS_W2_TBASE_OFF, d, 2'h0);
         bus_rd(`NBS_W2_TBASE_OFF, 2'h0, r);
         chk(r, d & 32'hffff_fff0);
         chk(tb, {32'h0, d & 32'hffff_fff0});
      end
      for (i = 0; i < 16; i++) begin
         d = $random(seed);
         d[2:0] = i[2:0];
         d[31] = i[3];
         e = fs(d);
         bus_wr(`NBS_W3_SETUP_OFF, d, 2'h0);
         bus_rd(`NBS_W3_SETUP_OFF, 2'h0, r);
         chk(r, e);
         chk(w3, e[31] ? {e[31], e[0], e[2:1], e[3], e[9:4]} : 11'h0);
      end
      chk(w2, 11'h0);
      bus_wr(`NBS_W2_SETUP_OFF, 32'h8000_0004, 2'h0);
      d = $random(seed);
      bus_wr(`NBS_W1_TBASE_OFF, d, 2'h0);
      bus_wr(`NBS_W3_SETUP_OFF, 32'h8000_0009, 2'h0);
      bus_rd(`NBS_W3_SETUP_OFF, 2'h0, r);
      chk(r, 32'h0);
      chk({p64, w3}, 12'h800);
      chk(w2, 11'h500);
      rst_n <= 0;
      repeat (2) @(posedge clk);
      rst_n <= 1;
      bus_rd(`NBS_W1_TBASE_OFF, 2'h0, r);
      chk({r, tb[63:32]}, {d, d});
      bus_wr(`NBS_W2_SETUP_OFF, 32'h8000_0005, 2'h0);
      bus_rd(`NBS_W2_SETUP_OFF, 2'h0, r);
      chk({p64, r}, 33'h0_8000_0001);
      bus_wr(12'h0a0, d, 2'h2);
      bus_rd(12'h0a0, 2'h2, r);
      chk(r, 32'h0);
      complete_run;
   end
endmodule
`default_nettype wire
